// ### logic/amx_defs.svh
// constants of the address map and exception entry block
// assumes inclusion by bare name from every file that needs them
`ifndef AMX_DEFS_SVH
`define AMX_DEFS_SVH
// register numbers on the register port
`define AMX_REG_BADVADDR 5'h08
`define AMX_REG_STATUS   5'h0c
`define AMX_REG_CAUSE    5'h0d
`define AMX_REG_RESUME   5'h0e
// vectors
`define AMX_VEC_RESET     32'hbfc0_0000
`define AMX_VEC_GEN       32'h8000_0080
`define AMX_VEC_GEN_BOOT  32'hbfc0_0180
`define AMX_VEC_UREF      32'h8000_0000
`define AMX_VEC_UREF_BOOT 32'hbfc0_0100
// address map
`define AMX_USEG_BASE   32'h4000_0000
`define AMX_ONCHIP_USER 8'h7f
`define AMX_ONCHIP_KERN 8'hff
`define AMX_DEBUG_TAG   11'h7f9
// status fields
`define AMX_ST_CU_HI  31
`define AMX_ST_CU_LO  28
`define AMX_ST_RE     25
`define AMX_ST_BEV    22
`define AMX_ST_TS     21
`define AMX_ST_NMI    20
`define AMX_ST_IM_HI  15
`define AMX_ST_IM_LO  8
`define AMX_ST_KU_HI  5
// cause fields
`define AMX_CA_BD     31
`define AMX_CA_CE_HI  29
`define AMX_CA_CE_LO  28
`define AMX_CA_IP_HI  15
`define AMX_CA_IP_LO  10
`define AMX_CA_SW_HI  9
`define AMX_CA_SW_LO  8
`define AMX_CA_EC_HI  6
`define AMX_CA_EC_LO  2
// reset values
`define AMX_RST_BEV   1'b1
`define AMX_RST_TS    1'b1
`define AMX_RST_NMI   1'b0
`define AMX_RST_KUIE  6'h00
`endif

// ### logic/amx_pkg.sv
// types shared by the address map and exception entry block
// assumes nothing of its surroundings
package amx_pkg;
  typedef enum logic [4:0] {
    EXC_INT  = 5'h00,
    EXC_MOD  = 5'h01,
    EXC_RFL  = 5'h02,
    EXC_RFS  = 5'h03,
    EXC_ADDRESS_ERROR_LOAD = 5'h04,
    EXC_ADDRESS_ERROR_STORE = 5'h05,
    EXC_IBE  = 5'h06,
    EXC_DBE  = 5'h07,
    EXC_SYS  = 5'h08,
    EXC_BP   = 5'h09,
    EXC_RI   = 5'h0a,
    EXC_CPU  = 5'h0b,
    EXC_OV   = 5'h0c
  } amx_exc_code_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } amx_size_t;
endpackage

// ### logic/amx_pin_sync.sv
// three-stage synchroniser with a filtered level for one pin
// assumes the pin idles at the reset level given by the parameter
`timescale 1ns/1ns
module amx_pin_sync #(
  parameter logic IDLE = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      level_reg <= IDLE;
    end else if (s2_reg == s3_reg) begin
      level_reg <= s3_reg;
    end
  end

  assign o_level = level_reg;
  assign o_fall  = level_reg & ~s3_reg & ~s2_reg;
endmodule

// ### logic/amx_addr_map.sv
// fixed segment translation, cache attribute and address checks
// assumes a purely combinational use inside one clock cycle
`timescale 1ns/1ns
`include "amx_defs.svh"
module amx_addr_map (
  input  wire logic [31:0] i_vaddr,
  input  wire logic [1:0]  i_size,
  input  wire logic        i_user,
  output logic      [31:0] o_paddr,
  output logic             o_cacheable,
  output logic             o_onchip,
  output logic             o_debug_area,
  output logic             o_addr_err
);
  logic misalign;
  logic priv_err;

  always_comb begin
    o_onchip     = 1'b0;
    o_debug_area = 1'b0;
    if (!i_vaddr[31]) begin
      o_paddr     = i_vaddr + `AMX_USEG_BASE;
      o_onchip    = (i_vaddr[31:24] == `AMX_ONCHIP_USER);
      o_cacheable = ~o_onchip;
    end else if (i_vaddr[31:29] == 3'h4) begin
      o_paddr     = {3'h0, i_vaddr[28:0]};
      o_cacheable = 1'b1;
    end else if (i_vaddr[31:29] == 3'h5) begin
      o_paddr     = {3'h0, i_vaddr[28:0]};
      o_cacheable = 1'b0;
    end else begin
      o_paddr      = i_vaddr;
      o_onchip     = (i_vaddr[31:24] == `AMX_ONCHIP_KERN);
      o_cacheable  = ~o_onchip;
      o_debug_area = (i_vaddr[31:21] == `AMX_DEBUG_TAG);
    end
  end

  always_comb begin
    misalign = 1'b0;
    if (i_size == amx_pkg::SZ_WORD) begin
      misalign = (i_vaddr[1:0] != 2'h0);
    end else if (i_size == amx_pkg::SZ_HALF) begin
      misalign = i_vaddr[0];
    end
  end

  // every kernel segment is closed to user mode
  assign priv_err   = i_user & i_vaddr[31];
  assign o_addr_err = misalign | priv_err;
endmodule

// ### logic/amx_core_exc.sv
// exception entry, mode stack and system registers of the core
// assumes event inputs are one-cycle pulses at commit
// and that far-side error inputs are synchronous to the core clock
`timescale 1ns/1ns
`include "amx_defs.svh"
//
// Contract
// - user mode reaches only top-bit-clear addresses
// - user segment maps linearly at 0x40000000
// - top 16 MB of user segment uncached
// - kernel cached segment maps low, cacheable
// - kernel uncached segment maps low, uncached
// - upper kernel segment identity mapped, cacheable
// - top 16 MB uncached; debug sub-range flagged
// - exception enters kernel until return instruction
// - exception flushes pipeline, fetches chosen vector
// - resume address; branch address for slot
// - reset release raises reset exception vector
// - falling nmi edge raises nmi exception
// - general and refill vectors follow boot select
// - cause codes zero through twelve encoded
// - misaligned or privileged access: address error
// - bus error input gives fetch/data error
// - trapping add/sub overflow raises overflow
// - system_call_instr, break, reserved opcode exceptions
// - unusable coprocessor instruction raises exception
// - protection fault reported as refill code
// - delay slot sets branch delay flag
// - return instruction pops mode stack
// - reset exception sets boot vector select
module amx_core_exc (
  // clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SYS_RST,
  // register port
  input  wire logic [4:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [31:0] O_REG_RDATA,
  // memory access check
  input  wire logic        I_ACC_VALID,
  input  wire logic [31:0] I_ACC_VADDR,
  input  wire logic [1:0]  I_ACC_SIZE,
  input  wire logic        I_ACC_STORE,
  input  wire logic        I_ACC_FETCH,
  output logic      [31:0] O_ACC_PADDR,
  output logic             O_ACC_CACHEABLE,
  output logic             O_ACC_ONCHIP,
  output logic             O_ACC_DEBUG_AREA,
  output logic             O_ACC_FAULT,
  // pipeline events
  input  wire logic [31:0] I_EXC_PC,
  input  wire logic [31:0] I_BRANCH_PC,
  input  wire logic        I_IN_DELAY_SLOT,
  input  wire logic        I_SYSTEM_CALL_INSTR,
  input  wire logic        I_BREAK,
  input  wire logic        I_RESERVED_INSTR,
  input  wire logic        I_COP_INSTR,
  input  wire logic [1:0]  I_COP_NUM,
  input  wire logic        I_ALU_TRAP,
  input  wire logic        I_ALU_SUB,
  input  wire logic [31:0] I_ALU_A,
  input  wire logic [31:0] I_ALU_B,
  input  wire logic        I_RFE,
  // far side
  input  wire logic        I_BUS_ERR,
  input  wire logic        I_BUS_ERR_FETCH,
  input  wire logic        I_PROT_FAULT,
  input  wire logic        I_PROT_STORE,
  input  wire logic        I_UREFILL,
  input  wire logic [5:0]  I_INT_REQ,
  input  wire logic        I_NMI_N,
  // pipeline control
  output logic             O_FLUSH,
  output logic             O_REDIRECT,
  output logic      [31:0] O_REDIRECT_ADDR,
  output logic             O_KERNEL_MODE,
  output logic             O_INT_ENABLE
);
  // status fields
  logic [3:0]  cu_reg;
  logic        re_reg;
  logic        bev_reg;
  logic        nmi_flag_reg;
  logic [7:0]  int_mask_reg;
  logic [5:0]  kuie_reg;
  // cause fields
  logic        bd_reg;
  logic [1:0]  ce_reg;
  logic [1:0]  sw_int_reg;
  logic [4:0]  code_reg;
  // address registers
  logic [31:0] resume_address_reg;
  logic [31:0] bad_vaddr_reg;
  // reset exception pends until the first edge
  logic        rst_exc_reg;
  logic        redirect_reg;
  logic [31:0] redirect_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] paddr_reg;
  logic        cache_reg;
  logic        onchip_reg;
  logic        debug_reg;

  logic [31:0] map_paddr;
  logic        map_cache;
  logic        map_onchip;
  logic        map_debug;
  logic        map_err;
  logic        nmi_fall;
  logic        user_mode;
  logic        acc_err;
  logic [31:0] alu_b_eff;
  logic [31:0] alu_sum;
  logic        ovf;
  logic        cop_unusable;
  logic        int_pend;
  logic        take;
  logic        take_code;
  logic        use_uref;
  logic        capture_bad;
  logic [4:0]  code_next;
  logic [31:0] vec_next;
  logic        wr_status;
  logic        wr_cause;
  logic [31:0] status_word;
  logic [31:0] cause_word;

  assign user_mode = kuie_reg[1];

  amx_addr_map u_map (
    .i_vaddr      (I_ACC_VADDR),
    .i_size       (I_ACC_SIZE),
    .i_user       (user_mode),
    .o_paddr      (map_paddr),
    .o_cacheable  (map_cache),
    .o_onchip     (map_onchip),
    .o_debug_area (map_debug),
    .o_addr_err   (map_err)
  );

  amx_pin_sync #(
    .IDLE (1'b1)
  ) u_nmi_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_pin   (I_NMI_N),
    .o_level (),
    .o_fall  (nmi_fall)
  );

  assign acc_err   = I_ACC_VALID & map_err;
  assign alu_b_eff = I_ALU_SUB ? ~I_ALU_B : I_ALU_B;
  assign alu_sum   = I_ALU_A + alu_b_eff + {31'h0, I_ALU_SUB};
  // two's complement overflow: like signs in, other sign out
  assign ovf = I_ALU_TRAP & (I_ALU_A[31] == alu_b_eff[31])
             & (alu_sum[31] != I_ALU_A[31]);
  // coprocessor 0 is always usable in kernel mode
  assign cop_unusable = I_COP_INSTR & ~cu_reg[I_COP_NUM]
                      & ~((I_COP_NUM == 2'h0) & ~user_mode);
  assign int_pend = kuie_reg[0]
                  & ((int_mask_reg & {I_INT_REQ, sw_int_reg}) != 8'h00);

  // priority: reset, nmi, fetch faults, decode faults, data faults,
  // then interrupts; below reset and nmi the first true source names the code
  always_comb begin
    take        = 1'b1;
    take_code   = 1'b1;
    use_uref    = 1'b0;
    capture_bad = 1'b0;
    code_next   = amx_pkg::EXC_INT;
    if (rst_exc_reg) begin
      take_code = 1'b0;
    end else if (nmi_fall) begin
      take_code = 1'b0;
    end else if (acc_err & I_ACC_FETCH) begin
      code_next   = amx_pkg::EXC_ADDRESS_ERROR_LOAD;
      capture_bad = 1'b1;
    end else if (I_BUS_ERR & I_BUS_ERR_FETCH) begin
      code_next = amx_pkg::EXC_IBE;
    end else if (I_RESERVED_INSTR) begin
      code_next = amx_pkg::EXC_RI;
    end else if (cop_unusable) begin
      code_next = amx_pkg::EXC_CPU;
    end else if (I_SYSTEM_CALL_INSTR) begin
      code_next = amx_pkg::EXC_SYS;
    end else if (I_BREAK) begin
      code_next = amx_pkg::EXC_BP;
    end else if (ovf) begin
      code_next = amx_pkg::EXC_OV;
    end else if (acc_err) begin
      code_next   = I_ACC_STORE ? amx_pkg::EXC_ADDRESS_ERROR_STORE : amx_pkg::EXC_ADDRESS_ERROR_LOAD;
      capture_bad = 1'b1;
    end else if (I_UREFILL) begin
      code_next = I_PROT_STORE ? amx_pkg::EXC_RFS : amx_pkg::EXC_RFL;
      use_uref  = 1'b1;
    end else if (I_PROT_FAULT) begin
      code_next = I_PROT_STORE ? amx_pkg::EXC_RFS : amx_pkg::EXC_RFL;
    end else if (I_BUS_ERR) begin
      code_next = amx_pkg::EXC_DBE;
    end else if (int_pend) begin
      code_next = amx_pkg::EXC_INT;
    end else begin
      take      = 1'b0;
      take_code = 1'b0;
    end
  end

  // reset and nmi ignore the boot select bit
  always_comb begin
    if (rst_exc_reg | (~take_code & take)) begin
      vec_next = `AMX_VEC_RESET;
    end else if (use_uref) begin
      vec_next = bev_reg ? `AMX_VEC_UREF_BOOT : `AMX_VEC_UREF;
    end else begin
      vec_next = bev_reg ? `AMX_VEC_GEN_BOOT : `AMX_VEC_GEN;
    end
  end

  assign O_FLUSH     = take;
  assign O_ACC_FAULT = acc_err;
  assign wr_status   = I_REG_WR & (I_REG_ADDR == `AMX_REG_STATUS);
  assign wr_cause    = I_REG_WR & (I_REG_ADDR == `AMX_REG_CAUSE);

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rst_exc_reg <= 1'b1;
    end else begin
      rst_exc_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      redirect_reg      <= 1'b0;
      redirect_addr_reg <= 32'h0000_0000;
    end else begin
      redirect_reg <= take;
      if (take) begin
        redirect_addr_reg <= vec_next;
      end
    end
  end

  // mode stack; an exception beats a same-cycle return
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      kuie_reg <= `AMX_RST_KUIE;
    end else if (take) begin
      kuie_reg <= {kuie_reg[3:0], 2'h0};
    end else if (I_RFE) begin
      kuie_reg <= {kuie_reg[5:4], kuie_reg[5:2]};
    end else if (wr_status) begin
      kuie_reg <= I_REG_WDATA[`AMX_ST_KU_HI:0];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bev_reg <= `AMX_RST_BEV;
    end else if (rst_exc_reg) begin
      bev_reg <= 1'b1;
    end else if (wr_status) begin
      bev_reg <= I_REG_WDATA[`AMX_ST_BEV];
    end
  end

  // a new nmi edge wins over a written-one clear
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      nmi_flag_reg <= `AMX_RST_NMI;
    end else if (rst_exc_reg) begin
      nmi_flag_reg <= 1'b0;
    end else if (nmi_fall) begin
      nmi_flag_reg <= 1'b1;
    end else if (wr_status & I_REG_WDATA[`AMX_ST_NMI]) begin
      nmi_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cu_reg       <= 4'h0;
      re_reg       <= 1'b0;
      int_mask_reg <= 8'h00;
    end else if (wr_status) begin
      cu_reg       <= I_REG_WDATA[`AMX_ST_CU_HI:`AMX_ST_CU_LO];
      re_reg       <= I_REG_WDATA[`AMX_ST_RE];
      int_mask_reg <= I_REG_WDATA[`AMX_ST_IM_HI:`AMX_ST_IM_LO];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sw_int_reg <= 2'h0;
    end else if (wr_cause) begin
      sw_int_reg <= I_REG_WDATA[`AMX_CA_SW_HI:`AMX_CA_SW_LO];
    end
  end

  // reset and nmi keep the cause code
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      code_reg <= 5'h00;
      ce_reg   <= 2'h0;
    end else if (take_code) begin
      code_reg <= code_next;
      if (code_next == amx_pkg::EXC_CPU) begin
        ce_reg <= I_COP_NUM;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      resume_address_reg <= 32'h0000_0000;
      bd_reg             <= 1'b0;
    end else if (take & ~rst_exc_reg) begin
      resume_address_reg <= I_IN_DELAY_SLOT ? I_BRANCH_PC : I_EXC_PC;
      bd_reg             <= I_IN_DELAY_SLOT;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bad_vaddr_reg <= 32'h0000_0000;
    end else if (take_code & capture_bad) begin
      bad_vaddr_reg <= I_ACC_VADDR;
    end
  end

  // fault flag is combinational, the rest registered
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      paddr_reg  <= 32'h0000_0000;
      cache_reg  <= 1'b0;
      onchip_reg <= 1'b0;
      debug_reg  <= 1'b0;
    end else if (I_ACC_VALID) begin
      paddr_reg  <= map_paddr;
      cache_reg  <= map_cache;
      onchip_reg <= map_onchip;
      debug_reg  <= map_debug;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`AMX_ST_CU_HI:`AMX_ST_CU_LO] = cu_reg;
    status_word[`AMX_ST_RE]  = re_reg;
    status_word[`AMX_ST_BEV] = bev_reg;
    status_word[`AMX_ST_TS]  = `AMX_RST_TS;
    status_word[`AMX_ST_NMI] = nmi_flag_reg;
    status_word[`AMX_ST_IM_HI:`AMX_ST_IM_LO] = int_mask_reg;
    status_word[`AMX_ST_KU_HI:0] = kuie_reg;
  end

  always_comb begin
    cause_word = 32'h0000_0000;
    cause_word[`AMX_CA_BD] = bd_reg;
    cause_word[`AMX_CA_CE_HI:`AMX_CA_CE_LO] = ce_reg;
    cause_word[`AMX_CA_IP_HI:`AMX_CA_IP_LO] = I_INT_REQ;
    cause_word[`AMX_CA_SW_HI:`AMX_CA_SW_LO] = sw_int_reg;
    cause_word[`AMX_CA_EC_HI:`AMX_CA_EC_LO] = code_reg;
  end

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `AMX_REG_STATUS:   rdata_reg <= status_word;
        `AMX_REG_CAUSE:    rdata_reg <= cause_word;
        `AMX_REG_RESUME:   rdata_reg <= resume_address_reg;
        `AMX_REG_BADVADDR: rdata_reg <= bad_vaddr_reg;
        default:           rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign O_REG_RDATA      = rdata_reg;
  assign O_ACC_PADDR      = paddr_reg;
  assign O_ACC_CACHEABLE  = cache_reg;
  assign O_ACC_ONCHIP     = onchip_reg;
  assign O_ACC_DEBUG_AREA = debug_reg;
  assign O_REDIRECT       = redirect_reg;
  assign O_REDIRECT_ADDR  = redirect_addr_reg;
  assign O_KERNEL_MODE    = ~kuie_reg[1];
  assign O_INT_ENABLE     = kuie_reg[0];
endmodule

// ### verif/amx_far_side.sv
// bus interface and protection circuit at the core's far side
// assumes the bench commands each error for one core clock cycle
`timescale 1ns/1ns
module amx_far_side (
  // commands from the bench
  input  wire logic i_berr_cmd,
  input  wire logic i_fetch_cmd,
  input  wire logic i_prot_cmd,
  input  wire logic i_store_cmd,
  // pins towards the core
  output logic      o_bus_err,
  output logic      o_bus_err_fetch,
  output logic      o_prot_fault,
  output logic      o_prot_store
);
  // qualifiers read low outside an error
  assign o_bus_err       = i_berr_cmd;
  assign o_bus_err_fetch = i_berr_cmd & i_fetch_cmd;
  assign o_prot_fault    = i_prot_cmd;
  assign o_prot_store    = i_prot_cmd & i_store_cmd;
endmodule

// ### verif/amx_core_exc_sva.sv
// checker on the ports of the address map and exception entry block
// assumes one clock domain and the reset held for at least one edge
`timescale 1ns/1ns
module amx_core_exc_sva (
  input wire logic        I_REF_CLK,
  input wire logic        I_SYS_RST,
  input wire logic [4:0]  I_REG_ADDR,
  input wire logic        I_REG_WR,
  input wire logic        I_ACC_VALID,
  input wire logic [31:0] I_ACC_VADDR,
  input wire logic [31:0] O_ACC_PADDR,
  input wire logic        O_ACC_CACHEABLE,
  input wire logic        O_ACC_ONCHIP,
  input wire logic        O_ACC_DEBUG_AREA,
  input wire logic        O_ACC_FAULT,
  input wire logic        I_SYSTEM_CALL_INSTR,
  input wire logic        I_RFE,
  input wire logic        I_BUS_ERR,
  input wire logic        I_PROT_FAULT,
  input wire logic        I_NMI_N,
  input wire logic        O_FLUSH,
  input wire logic        O_REDIRECT,
  input wire logic [31:0] O_REDIRECT_ADDR,
  input wire logic        O_KERNEL_MODE,
  input wire logic        O_INT_ENABLE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_entry;
    O_FLUSH ##1 (O_REDIRECT && O_KERNEL_MODE && !O_INT_ENABLE);
  endsequence
  a_user_fault: assert property (I_ACC_VALID && !O_KERNEL_MODE && I_ACC_VADDR[31]
    |-> O_ACC_FAULT) else $error("user fault");
  a_useg_map: assert property (I_ACC_VALID && !I_ACC_VADDR[31]
    |=> O_ACC_PADDR == $past(I_ACC_VADDR) + 32'h4000_0000) else $error("user map wrong");
  a_user_onchip: assert property (I_ACC_VALID && I_ACC_VADDR[31:24] == 8'h7f
    |=> O_ACC_ONCHIP && !O_ACC_CACHEABLE) else $error("user onchip");
  a_kseg_cached: assert property (I_ACC_VALID && I_ACC_VADDR[31:29] == 3'h4
    |=> O_ACC_CACHEABLE && O_ACC_PADDR == {3'h0, $past(I_ACC_VADDR[28:0])})
    else $error("cached map");
  a_kseg_uncached: assert property (I_ACC_VALID && I_ACC_VADDR[31:29] == 3'h5
    |=> !O_ACC_CACHEABLE && O_ACC_PADDR == {3'h0, $past(I_ACC_VADDR[28:0])})
    else $error("uncached map");
  a_upper_ident: assert property (I_ACC_VALID && I_ACC_VADDR[31:30] == 2'h3
    |=> O_ACC_PADDR == $past(I_ACC_VADDR)
    && O_ACC_CACHEABLE == ($past(I_ACC_VADDR[31:24]) != 8'hff)) else $error("upper map wrong");
  a_debug_area: assert property (I_ACC_VALID
    |=> O_ACC_DEBUG_AREA == ($past(I_ACC_VADDR[31:21]) == 11'h7f9)) else $error("debug flag");
  a_system_call_instr_entry: assert property (I_SYSTEM_CALL_INSTR |-> s_entry) else $error("entry missed");
  a_stay_kernel: assert property (O_KERNEL_MODE && !I_RFE
    && !(I_REG_WR && I_REG_ADDR == 5'h0c) |=> O_KERNEL_MODE) else $error("left kernel mode");
  a_redirect_cause: assert property (!O_FLUSH |=> !O_REDIRECT) else $error("stray redirect");
  a_reset_vector: assert property ($fell(I_SYS_RST)
    |=> O_REDIRECT && O_REDIRECT_ADDR == 32'hbfc0_0000) else $error("no reset vector");
  a_nmi_edge: assert property ($fell(I_NMI_N) |-> ##[1:6] O_FLUSH) else $error("nmi lost");
  a_bus_error: assert property (I_BUS_ERR |-> s_entry) else $error("bus error lost");
  a_prot_fault: assert property (I_PROT_FAULT |-> s_entry) else $error("prot lost");
endmodule
bind amx_core_exc amx_core_exc_sva u_amx_core_exc_sva (.*);

// ### verif/tb_amx_core_exc.sv
// self-checking bench for the address map and exception entry block
// assumes the far-side model drives the error pins
`timescale 1ns/1ns
`include "amx_defs.svh"
module tb_amx_core_exc;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  ra = 5'h00;
  logic [31:0] wd = 32'h0, pc = 32'h1000, bpc = 32'h0ffc, av = 32'h0, ea = 32'h0, eb = 32'h0;
  logic        wr = 0, rd = 0, av_v = 0, st = 0, fe = 0, slot = 0, sc = 0, bk = 0, ri = 0;
  logic        cop = 0, trap = 0, sub = 0, return_from_exception_instr = 0, nmi_n = 1, ur = 0;
  logic        c_be = 0, c_bf = 0, c_pf = 0, c_ps = 0;
  logic [1:0]  sz = 2'h2, cn = 2'h1;
  logic [5:0]  irq = 6'h0;
  logic [31:0] rdata, paddr, raddr;
  logic        cach, onc, dbg, flt, flush, redir, kern, ie, be, bf, pf, ps;
  int          mismatches = 0;
  int          compares = 0;
  always #4 clk = ~clk;
  amx_far_side u_amx_far_side (.i_berr_cmd(c_be), .i_fetch_cmd(c_bf),
    .i_prot_cmd(c_pf), .i_store_cmd(c_ps), .o_bus_err(be), .o_bus_err_fetch(bf),
    .o_prot_fault(pf), .o_prot_store(ps));
  amx_core_exc u_amx_core_exc (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(ra),
    .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_ACC_VALID(av_v),
    .I_ACC_VADDR(av), .I_ACC_SIZE(sz), .I_ACC_STORE(st), .I_ACC_FETCH(fe), .O_ACC_PADDR(paddr),
    .O_ACC_CACHEABLE(cach), .O_ACC_ONCHIP(onc), .O_ACC_DEBUG_AREA(dbg), .O_ACC_FAULT(flt),
    .I_EXC_PC(pc), .I_BRANCH_PC(bpc), .I_IN_DELAY_SLOT(slot), .I_SYSTEM_CALL_INSTR(sc), .I_BREAK(bk),
    .I_RESERVED_INSTR(ri), .I_COP_INSTR(cop), .I_COP_NUM(cn), .I_ALU_TRAP(trap),
    .I_ALU_SUB(sub), .I_ALU_A(ea), .I_ALU_B(eb), .I_RFE(return_from_exception_instr), .I_BUS_ERR(be),
    .I_BUS_ERR_FETCH(bf), .I_PROT_FAULT(pf), .I_PROT_STORE(ps), .I_UREFILL(ur),
    .I_INT_REQ(irq), .I_NMI_N(nmi_n), .O_FLUSH(flush), .O_REDIRECT(redir),
    .O_REDIRECT_ADDR(raddr), .O_KERNEL_MODE(kern), .O_INT_ENABLE(ie));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic mapchk(input logic [31:0] va, input logic [31:0] pa, input logic [2:0] at);
    @(posedge clk);
    av_v <= 1'b1;
    av <= va;
    #1 chk({31'h0, flt}, 32'h0);
    @(posedge clk);
    av_v <= 1'b0;
    #1 chk(paddr, pa);
    chk({29'h0, cach, onc, dbg}, {29'h0, at});
  endtask
  // one source per kind, dropped after the flush
  task automatic fire(input int k, input logic s, input logic [31:0] vec, input logic [4:0] code);
    logic [31:0] v;
    @(posedge clk);
    pc <= pc + 32'h10;
    bpc <= pc + 32'hc;
    slot <= s;
    case (k)
      0: sc <= 1'b1;
      1: bk <= 1'b1;
      2: ri <= 1'b1;
      3: cop <= 1'b1;
      4: {trap, sub, ea, eb} <= {2'b10, 32'h7fff_ffff, 32'h1};
      5: {trap, sub, ea, eb} <= {2'b11, 32'h8000_0000, 32'h1};
      6: {c_be, c_bf} <= 2'b11;
      7: c_be <= 1'b1;
      8: c_pf <= 1'b1;
      9: {c_pf, c_ps} <= 2'b11;
      10: {av_v, st, av} <= {2'b11, 32'h8000_0002};
      11: {av_v, fe, av} <= {2'b11, 32'h8000_0001};
      12: {av_v, av} <= {1'b1, 32'h8000_0000};
      14: ur <= 1'b1;
      default: irq <= 6'h01;
    endcase
    #1 chk({31'h0, flush}, 32'h1);
    @(posedge clk);
    {sc, bk, ri, cop, trap, c_be, c_bf, c_pf, c_ps, av_v, st, fe, ur} <= 13'h0;
    irq <= 6'h0;
    #1 chk({31'h0, redir}, 32'h1);
    chk(raddr, vec);
    reg_rd(`AMX_REG_CAUSE, v);
    chk({27'h0, v[6:2]}, {27'h0, code});
    chk({31'h0, v[31]}, {31'h0, s});
    reg_rd(`AMX_REG_RESUME, v);
    chk(v, s ? bpc : pc);
  endtask
  task automatic t_reset;
    logic [31:0] v;
    reg_rd(`AMX_REG_STATUS, v);
    chk(v, 32'h0060_0000);
    reg_rd(5'h01, v);
    chk(v, 32'h0);
    fire(1, 1'b0, `AMX_VEC_GEN_BOOT, amx_pkg::EXC_BP);
    reg_wr(`AMX_REG_STATUS, 32'h0);
    reg_rd(`AMX_REG_STATUS, v);
    chk(v, 32'h0020_0000);
    $display("test reset done");
  endtask
  task automatic t_map;
    mapchk(32'h0000_1000, 32'h4000_1000, 3'b100);
    mapchk(32'h7f00_0010, 32'hbf00_0010, 3'b010);
    mapchk(32'h8000_1000, 32'h0000_1000, 3'b100);
    mapchk(32'h9fff_fffc, 32'h1fff_fffc, 3'b100);
    mapchk(32'ha000_0000, 32'h0000_0000, 3'b000);
    mapchk(32'hbfff_fffc, 32'h1fff_fffc, 3'b000);
    mapchk(32'hc000_0000, 32'hc000_0000, 3'b100);
    mapchk(32'hfeff_fffc, 32'hfeff_fffc, 3'b100);
    mapchk(32'hff00_0000, 32'hff00_0000, 3'b010);
    mapchk(32'hff20_0000, 32'hff20_0000, 3'b011);
    mapchk(32'hff3f_fffc, 32'hff3f_fffc, 3'b011);
    mapchk(32'hff40_0000, 32'hff40_0000, 3'b010);
    $display("test map done");
  endtask
  task automatic t_codes;
    fire(0, 1'b1, `AMX_VEC_GEN, amx_pkg::EXC_SYS);
    fire(2, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_RI);
    fire(3, 1'b1, `AMX_VEC_GEN, amx_pkg::EXC_CPU);
    fire(4, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_OV);
    fire(5, 1'b1, `AMX_VEC_GEN, amx_pkg::EXC_OV);
    fire(6, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_IBE);
    fire(7, 1'b1, `AMX_VEC_GEN, amx_pkg::EXC_DBE);
    fire(8, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_RFL);
    fire(9, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_RFS);
    fire(10, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_ADDRESS_ERROR_STORE);
    fire(11, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_ADDRESS_ERROR_LOAD);
    fire(14, 1'b0, `AMX_VEC_UREF, amx_pkg::EXC_RFL);
    reg_wr(`AMX_REG_STATUS, 32'h0000_0401);
    fire(13, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_INT);
    @(posedge clk);
    {trap, sub, ea, eb} <= {2'b10, 32'h1, 32'h1};
    #1 chk({31'h0, flush}, 32'h0);
    @(posedge clk);
    trap <= 1'b0;
    $display("test codes done");
  endtask
  task automatic t_mode;
    logic [31:0] v;
    reg_wr(`AMX_REG_STATUS, 32'h0000_0003);
    #1 chk({30'h0, kern, ie}, 32'h1);
    fire(12, 1'b0, `AMX_VEC_GEN, amx_pkg::EXC_ADDRESS_ERROR_LOAD);
    chk({31'h0, kern}, 32'h1);
    reg_rd(`AMX_REG_STATUS, v);
    chk({26'h0, v[5:0]}, 32'h0c);
    @(posedge clk);
    return_from_exception_instr <= 1'b1;
    @(posedge clk);
    return_from_exception_instr <= 1'b0;
    #1 chk({31'h0, kern}, 32'h0);
    reg_rd(`AMX_REG_STATUS, v);
    chk({26'h0, v[5:0]}, 32'h03);
    reg_wr(`AMX_REG_STATUS, 32'h0);
    $display("test mode done");
  endtask
  task automatic t_nmi;
    logic [31:0] v;
    int          n;
    @(posedge clk);
    nmi_n <= 1'b0;
    n = 0;
    while (flush !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk({31'h0, flush}, 32'h1);
    @(posedge clk);
    #1 chk(raddr, `AMX_VEC_RESET);
    reg_rd(`AMX_REG_STATUS, v);
    chk({31'h0, v[`AMX_ST_NMI]}, 32'h1);
    reg_wr(`AMX_REG_STATUS, 32'h0010_0000);
    reg_rd(`AMX_REG_STATUS, v);
    chk({31'h0, v[`AMX_ST_NMI]}, 32'h0);
    nmi_n <= 1'b1;
    $display("test nmi done");
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // first cycle after release is the reset exception
    repeat (3) @(posedge clk);
    t_reset;
    t_map;
    t_codes;
    t_mode;
    t_nmi;
    test_done;
  end
endmodule
